// ### rtl/tmr_defines.vh
// constants for the bus time-out and tick timer block
// Functional notes
// - grant unanswered by busy for 256 us: drive busy, drop grant, re-arbitrate
// - global timer runs while a data strobe is low; expiry sends bus error
// - global select: 0=8 us, 1=64 us, 2=256 us, 3=off
// - global timer idle unless this device is system controller
// - dma on-time select 0..6 = 16..1024 us, 7 = until done
// - dma off-time select 0..7 = 0,16..1024 us minimum off the bus
// - watchdog select 0..15 = 512 us doubling to 1 s, then 4,16,32,64 s
// - access timer runs while waiting for mastership; expiry gives error ack
// - posted write expiry raises write-post error interrupt instead
// - access select: 0=64 us, 1=1 ms, 2=32 ms, 3=off
// - a prescaler write of 0xff is refused
// - tick rate is clock over 256 minus prescaler, at most half the clock
// - tick compare match: interrupt, overflow count up, clear if enabled
// - each 32-bit tick counter counts every us when enabled, software r/w
// - reset switch makes system reset only when its enable bit is set
// - board-fail force bit drives the board-fail pin
// - writing one to the power-up clear bit clears the flag; reads zero
// - power-up flag set by power-up reset until software clears it
// - board-fail status shows pin, driven by force bit or by watchdog expiry when its board-fail enable is set
// - prescaler low byte counts to max, reloads; each reload bumps upper 24 bits
// - system controller flag shows the system controller strap
`ifndef TMR_DEFINES_VH
`define TMR_DEFINES_VH
// register byte offsets
`define TMR_OFS_TIMEOUT   8'h4c
`define TMR_OFS_CMP1      8'h50
`define TMR_OFS_CNT1      8'h54
`define TMR_OFS_CMP2      8'h58
`define TMR_OFS_CNT2      8'h5c
`define TMR_OFS_BOARD     8'h60
`define TMR_OFS_PRESCALE  8'h64
// field positions in the time-out word
`define TMR_B_GRANT_EN    24
`define TMR_B_OFF_LSB     21
`define TMR_B_ON_LSB      18
`define TMR_B_GLOB_LSB    16
`define TMR_B_ACC_LSB     14
`define TMR_B_LOCAL_LSB   12
`define TMR_B_WDSEL_LSB   8
// field positions in the board word
`define TMR_B_SYSCON      30
`define TMR_B_SYSFAIL     29
`define TMR_B_BFAIL_IN    28
`define TMR_B_POWERUP     27
`define TMR_B_CLR_PU      26
`define TMR_B_BFAIL_FORCE 25
`define TMR_B_RSW_EN      24
`define TMR_B_WD_CLR_STAT 22
`define TMR_B_WD_RESTART  21
`define TMR_B_WD_STAT     20
`define TMR_B_WD_BFAIL    19
`define TMR_B_WD_EN       16
`define TMR_B_TT_EN       0
`define TMR_B_TT_COC      1
`define TMR_B_TT_COVF     2
`define TMR_B_TT_OVF_LSB  4
// reset values
`define TMR_RST_PRESCALE  8'hdf
`define TMR_PRESCALE_BAD  8'hff
// times in microseconds
`define TMR_US_GRANT      16'd256
`define TMR_US_GLOB0      16'd8
`define TMR_US_GLOB1      16'd64
`define TMR_US_GLOB2      16'd256
`define TMR_US_ACC0       16'd64
`define TMR_US_ACC1       16'd1000
`define TMR_US_ACC2       16'd32000
`define TMR_US_DMA_BASE   16'd16
`define TMR_US_WD0        32'd512
`define TMR_US_WD11       32'd1000000
`define TMR_US_WD12       32'd4000000
`define TMR_US_WD13       32'd16000000
`define TMR_US_WD14       32'd32000000
`define TMR_US_WD15       32'd64000000
`endif

// ### rtl/tmr_bus_timers.v
// bus time-outs, prescaler, tick timers and board control behind an apb slave
`timescale 1ns/10ps
`default_nettype none
`include "tmr_defines.vh"

module tmr_bus_timers #(
   parameter TICKS = 2
) (
   // clock and reset
   input  wire        mclk,
   input  wire        nrst,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // arbiter side
   input  wire        grant_active,
   input  wire        bbsy_seen,
   output reg         grant_timeout,
   // data strobes and system controller
   input  wire        ds0_active,
   input  wire        ds1_active,
   input  wire        sys_controller,
   input  wire        sysfail_seen,
   output reg         berr_out,
   // dma tenure
   input  wire        dma_on_bus,
   output reg         dma_tenure_end,
   output reg         dma_off_hold,
   // local access waiting for mastership
   input  wire        access_pending,
   input  wire        access_posted,
   input  wire        is_bus_master,
   output reg         transfer_error_ack,
   output reg         wpost_err_irq,
   // tick timers, board pins
   output reg  [1:0]  tick_irq,
   input  wire        reset_switch,
   output reg         sysreset_out,
   output reg         board_fail_pin
);

   // control registers
   reg        grant_timeout_en;
   reg  [1:0] global_timeout_sel;
   reg  [2:0] dma_on_sel;
   reg  [2:0] dma_off_sel;
   reg  [1:0] access_timeout_sel;
   reg  [1:0] unused_local_timeout;
   reg  [3:0] watchdog_period_sel;
   reg  [7:0] prescaler_adjust;
   reg        reset_switch_en;
   reg        board_fail_force;
   reg        powerup_flag;
   reg        wd_en;
   reg        wd_bfail_en;
   reg        wd_expired;
   reg [31:0] presc;
   reg        us_tick;
   reg [31:0] tick_cmp [0:1];
   reg [31:0] tick_cnt [0:1];
   reg  [1:0] tick_en;
   reg  [1:0] tick_coc;
   reg  [3:0] tick_ovf [0:1];
   // time-out counters in microseconds
   reg [15:0] grant_cnt;
   reg [15:0] glob_cnt;
   reg [15:0] on_cnt;
   reg [15:0] off_cnt;
   reg [15:0] acc_cnt;
   reg [25:0] wd_cnt;
   reg        acc_exp_q;
   reg        grant_exp_q;

   // bus decode
   // writes land at the edge where ready is sampled high
   wire       wr_en    = psel & penable & pwrite & pready;
   wire       wr_tmo   = wr_en & (paddr == `TMR_OFS_TIMEOUT);
   wire       wr_board = wr_en & (paddr == `TMR_OFS_BOARD);
   wire       wd_restart = wr_board & pwdata[`TMR_B_WD_RESTART];
   wire       mapped   = (paddr == `TMR_OFS_TIMEOUT) | (paddr == `TMR_OFS_CMP1) |
                         (paddr == `TMR_OFS_CNT1) | (paddr == `TMR_OFS_CMP2) |
                         (paddr == `TMR_OFS_CNT2) | (paddr == `TMR_OFS_BOARD) |
                         (paddr == `TMR_OFS_PRESCALE);

   // limits chosen by the select fields
   reg [15:0] glob_lim;
   reg [15:0] acc_lim;
   reg [31:0] wd_lim;
   always @* begin
      case (global_timeout_sel)
         2'd0:    glob_lim = `TMR_US_GLOB0;
         2'd1:    glob_lim = `TMR_US_GLOB1;
         default: glob_lim = `TMR_US_GLOB2;
      endcase
      case (access_timeout_sel)
         2'd0:    acc_lim = `TMR_US_ACC0;
         2'd1:    acc_lim = `TMR_US_ACC1;
         default: acc_lim = `TMR_US_ACC2;
      endcase
      case (watchdog_period_sel)
         4'd11:   wd_lim = `TMR_US_WD11;
         4'd12:   wd_lim = `TMR_US_WD12;
         4'd13:   wd_lim = `TMR_US_WD13;
         4'd14:   wd_lim = `TMR_US_WD14;
         4'd15:   wd_lim = `TMR_US_WD15;
         default: wd_lim = `TMR_US_WD0 * (32'd1 << watchdog_period_sel);
      endcase
   end

   // dma limits: 16 us doubled per code step, off code 0 gives 0
   wire [15:0] on_lim  = `TMR_US_DMA_BASE << dma_on_sel;
   wire [15:0] off_lim = (dma_off_sel == 3'd0) ? 16'd0 :
                         (`TMR_US_DMA_BASE << (dma_off_sel - 3'd1));

   // expiry levels
   wire glob_run  = (ds0_active | ds1_active) & sys_controller &
                    (global_timeout_sel != 2'd3);
   wire grant_run = grant_timeout_en & grant_active & ~bbsy_seen;
   wire acc_run   = access_pending & ~is_bus_master & (access_timeout_sel != 2'd3);
   wire grant_exp = grant_run & (grant_cnt == `TMR_US_GRANT);
   wire glob_exp  = glob_run & (glob_cnt == glob_lim);
   wire acc_exp   = acc_run & (acc_cnt == acc_lim);
   wire on_exp    = dma_on_bus & (dma_on_sel != 3'd7) & (on_cnt == on_lim);
   wire off_done  = off_cnt == off_lim;
   wire wd_exp    = wd_en & ({6'd0, wd_cnt} == wd_lim);
   wire bfail_lvl = board_fail_force | (wd_expired & wd_bfail_en);

   // apb slave, one wait state per access
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~mapped;
         prdata  <= 32'h0000_0000;
         if (psel & penable & ~pready & ~pwrite) begin
            case (paddr)
               `TMR_OFS_TIMEOUT: prdata <= {7'd0, grant_timeout_en, dma_off_sel, dma_on_sel,
                                            global_timeout_sel, access_timeout_sel,
                                            unused_local_timeout, watchdog_period_sel,
                                            prescaler_adjust};
               `TMR_OFS_CMP1:     prdata <= tick_cmp[0];
               `TMR_OFS_CNT1:     prdata <= tick_cnt[0];
               `TMR_OFS_CMP2:     prdata <= tick_cmp[1];
               `TMR_OFS_CNT2:     prdata <= tick_cnt[1];
               `TMR_OFS_PRESCALE: prdata <= presc;
               `TMR_OFS_BOARD: prdata <= {1'b0, sys_controller, sysfail_seen,
                                          board_fail_pin, powerup_flag, 1'b0,
                                          board_fail_force, reset_switch_en,
                                          3'd0, wd_expired, wd_bfail_en, 2'd0, wd_en,
                                          tick_ovf[1], 1'b0, 1'b0, tick_coc[1], tick_en[1],
                                          tick_ovf[0], 1'b0, 1'b0, tick_coc[0], tick_en[0]};
               default:           prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // control register writes
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         grant_timeout_en     <= 1'b0;
         global_timeout_sel   <= 2'd0;
         dma_on_sel           <= 3'd0;
         dma_off_sel          <= 3'd0;
         access_timeout_sel   <= 2'd0;
         unused_local_timeout <= 2'd0;
         watchdog_period_sel  <= 4'd0;
         prescaler_adjust     <= `TMR_RST_PRESCALE;
         reset_switch_en      <= 1'b1;
         board_fail_force     <= 1'b1;
         powerup_flag         <= 1'b1;
         wd_en                <= 1'b0;
         wd_bfail_en          <= 1'b0;
      end else begin
         if (wr_tmo) begin
            grant_timeout_en     <= pwdata[`TMR_B_GRANT_EN];
            dma_off_sel          <= pwdata[`TMR_B_OFF_LSB +: 3];
            dma_on_sel           <= pwdata[`TMR_B_ON_LSB +: 3];
            global_timeout_sel   <= pwdata[`TMR_B_GLOB_LSB +: 2];
            access_timeout_sel   <= pwdata[`TMR_B_ACC_LSB +: 2];
            unused_local_timeout <= pwdata[`TMR_B_LOCAL_LSB +: 2];
            watchdog_period_sel  <= pwdata[`TMR_B_WDSEL_LSB +: 4];
            if (pwdata[7:0] != `TMR_PRESCALE_BAD)
               prescaler_adjust <= pwdata[7:0];
         end
         if (wr_board) begin
            reset_switch_en  <= pwdata[`TMR_B_RSW_EN];
            board_fail_force <= pwdata[`TMR_B_BFAIL_FORCE];
            wd_en            <= pwdata[`TMR_B_WD_EN];
            wd_bfail_en      <= pwdata[`TMR_B_WD_BFAIL];
            if (pwdata[`TMR_B_CLR_PU])
               powerup_flag <= 1'b0;
         end
      end
   end

   // prescaler: low byte runs at clock rate, reload bumps the upper part
   // 0xff is never held, so the tick is at most half the clock rate
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         presc   <= 32'h0000_0000;
         us_tick <= 1'b0;
      end else if (presc[7:0] == 8'hff) begin
         presc   <= {presc[31:8] + 24'd1, prescaler_adjust};
         us_tick <= 1'b1;
      end else begin
         presc   <= {presc[31:8], presc[7:0] + 8'd1};
         us_tick <= 1'b0;
      end
   end

   // microsecond time-out counters, held at their limit once reached
   // holding keeps each expiry level up until its cause ends
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         grant_cnt <= 16'd0;
         glob_cnt  <= 16'd0;
         acc_cnt   <= 16'd0;
         on_cnt    <= 16'd0;
         off_cnt   <= 16'd0;
      end else begin
         if (!grant_run)
            grant_cnt <= 16'd0;
         else if (us_tick && !grant_exp)
            grant_cnt <= grant_cnt + 16'd1;
         if (!glob_run)
            glob_cnt <= 16'd0;
         else if (us_tick && !glob_exp)
            glob_cnt <= glob_cnt + 16'd1;
         if (!acc_run)
            acc_cnt <= 16'd0;
         else if (us_tick && !acc_exp)
            acc_cnt <= acc_cnt + 16'd1;
         if (!dma_on_bus)
            on_cnt <= 16'd0;
         else if (us_tick && on_cnt != on_lim)
            on_cnt <= on_cnt + 16'd1;
         if (dma_on_bus)
            off_cnt <= 16'd0;
         else if (us_tick && !off_done)
            off_cnt <= off_cnt + 16'd1;
      end
   end

   // watchdog: restart by software, sticky expiry, set beats clear
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         wd_cnt     <= 26'd0;
         wd_expired <= 1'b0;
      end else begin
         if (!wd_en || wd_restart)
            wd_cnt <= 26'd0;
         else if (us_tick && !wd_exp)
            wd_cnt <= wd_cnt + 26'd1;
         // an expiry in the clear cycle wins, so no time-out is lost
         if (wd_exp)
            wd_expired <= 1'b1;
         else if (wr_board && pwdata[`TMR_B_WD_CLR_STAT])
            wd_expired <= 1'b0;
      end
   end

   // event outputs and pins
   // access errors pulse once per expiry, steered by the posted flag
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         acc_exp_q          <= 1'b0;
         grant_exp_q        <= 1'b0;
         grant_timeout      <= 1'b0;
         berr_out           <= 1'b0;
         dma_tenure_end     <= 1'b0;
         dma_off_hold       <= 1'b0;
         transfer_error_ack <= 1'b0;
         wpost_err_irq      <= 1'b0;
         sysreset_out       <= 1'b0;
         board_fail_pin     <= 1'b0;
      end else begin
         acc_exp_q          <= acc_exp;
         grant_exp_q        <= grant_exp;
         grant_timeout      <= grant_exp & ~grant_exp_q;
         berr_out           <= glob_exp;
         dma_tenure_end     <= on_exp;
         dma_off_hold       <= ~dma_on_bus & ~off_done;
         transfer_error_ack <= acc_exp & ~acc_exp_q & ~access_posted;
         wpost_err_irq      <= acc_exp & ~acc_exp_q & access_posted;
         sysreset_out       <= reset_switch & reset_switch_en;
         board_fail_pin     <= bfail_lvl;
      end
   end

   // tick timers, one per generate entry
   genvar t;
   generate
      for (t = 0; t < TICKS; t = t + 1) begin : g_tick
         // only entries 0 and 1 have registers in the map
         wire [7:0]  cmp_ofs = (t == 1) ? `TMR_OFS_CMP2 : `TMR_OFS_CMP1;
         wire [7:0]  cnt_ofs = (t == 1) ? `TMR_OFS_CNT2 : `TMR_OFS_CNT1;
         // matching count plus one makes the period equal the compare value
         wire [31:0] inc     = tick_cnt[t] + 32'd1;
         wire        hit     = tick_en[t] & us_tick & (inc == tick_cmp[t]);
         always @(posedge mclk or negedge nrst) begin
            if (!nrst) begin
               tick_cmp[t] <= 32'h0000_0000;
               tick_cnt[t] <= 32'h0000_0000;
               tick_en[t]  <= 1'b0;
               tick_coc[t] <= 1'b0;
               tick_ovf[t] <= 4'd0;
               tick_irq[t] <= 1'b0;
            end else begin
               tick_irq[t] <= hit;
               if (wr_en && paddr == cmp_ofs)
                  tick_cmp[t] <= pwdata;
               if (wr_en && paddr == cnt_ofs)
                  tick_cnt[t] <= pwdata;
               else if (hit && tick_coc[t])
                  tick_cnt[t] <= 32'h0000_0000;
               else if (tick_en[t] && us_tick)
                  tick_cnt[t] <= inc;
               if (wr_board) begin
                  tick_en[t]  <= pwdata[8*t + `TMR_B_TT_EN];
                  tick_coc[t] <= pwdata[8*t + `TMR_B_TT_COC];
               end
               if (hit)
                  tick_ovf[t] <= tick_ovf[t] + 4'd1;
               else if (wr_board && pwdata[8*t + `TMR_B_TT_COVF])
                  tick_ovf[t] <= 4'd0;
            end
         end
      end
   endgenerate

endmodule
`default_nettype wire

// ### bench/tmr_bus_timers_asserts.sv
// port checker for the bus time-out and tick timer block
`timescale 1ns/10ps
`default_nettype none
module tmr_bus_timers_asserts (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        nrst,
   // apb
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pready,
   input  wire logic        pslverr,
   input  wire logic [31:0] prdata,
   // arbiter and strobes
   input  wire logic        grant_active,
   input  wire logic        bbsy_seen,
   input  wire logic        grant_timeout,
   input  wire logic        ds0_active,
   input  wire logic        ds1_active,
   input  wire logic        sys_controller,
   input  wire logic        berr_out,
   // local access, ticks, switch
   input  wire logic        access_pending,
   input  wire logic        access_posted,
   input  wire logic        is_bus_master,
   input  wire logic        transfer_error_ack,
   input  wire logic        wpost_err_irq,
   input  wire logic [1:0]  tick_irq,
   input  wire logic        reset_switch,
   input  wire logic        sysreset_out
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);
   // apb answer timing
   a_apb_wait_state: assert property (psel && penable && !pready |=> pready)
      else $error("no answer after one wait state");
   a_apb_err_ready: assert property (pslverr |-> pready)
      else $error("error flag without ready");
   a_apb_idle_data: assert property (!pready |-> prdata == 32'h0000_0000)
      else $error("read data outside answer");
   // time-out and switch outputs tied to their causes, tick pulse width
   a_berr_strobe: assert property (berr_out |-> $past(ds0_active || ds1_active))
      else $error("bus error without strobe");
   a_berr_syscon: assert property (berr_out |-> $past(sys_controller))
      else $error("bus error while not system controller");
   a_grant_cause: assert property (grant_timeout |-> $past(grant_active && !bbsy_seen))
      else $error("grant timeout without unanswered grant");
   a_grant_early: assert property ($rose(grant_active) |-> !grant_timeout [*8])
      else $error("grant timeout too soon");
   a_tea_cause: assert property (transfer_error_ack |->
      $past(access_pending && !access_posted && !is_bus_master))
      else $error("error ack without waiting non-posted access");
   a_wpost_cause: assert property (wpost_err_irq |-> $past(access_pending && access_posted))
      else $error("post error without posted access");
   a_err_exclusive: assert property (!(transfer_error_ack && wpost_err_irq))
      else $error("both access errors at once");
   a_tick_pulse: assert property (tick_irq[0] |=> !tick_irq[0])
      else $error("tick interrupt longer than a pulse");
   a_switch_cause: assert property (sysreset_out |-> $past(reset_switch))
      else $error("system reset without switch");
   // main scenarios reached
   c_berr: cover property (berr_out);
   c_grant: cover property (grant_timeout);
   c_tick: cover property (tick_irq[1]);
   c_wpost: cover property (wpost_err_irq);
endmodule
bind tmr_bus_timers tmr_bus_timers_asserts tmr_bus_timers_asserts_inst (.*);
`default_nettype wire

// ### bench/tmr_vme_far.sv
// far-side model: a strobing master and a granted requester
`timescale 1ns/10ps
`default_nettype none
module tmr_vme_far (
   // clock and reset
   input  wire logic mclk,
   input  wire logic nrst,
   // bench commands
   input  wire logic strobe_go,
   input  wire logic grant_go,
   input  wire logic bbsy_prompt,
   // device answers
   input  wire logic berr_out,
   input  wire logic grant_timeout,
   // far-side lines
   output var logic  ds0_active,
   output var logic  ds1_active,
   output var logic  grant_active,
   output var logic  bbsy_seen
);
   logic       ds_done;
   logic       gnt_done;
   logic [3:0] wait_cnt;
   // strobes drop on bus error; grant drops on timeout; prompt mode answers busy
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ds_done <= 1'b0;
         ds0_active <= 1'b0;
         ds1_active <= 1'b0;
         gnt_done <= 1'b0;
         grant_active <= 1'b0;
         wait_cnt <= 4'h0;
         bbsy_seen <= 1'b0;
      end else begin
         ds_done      <= strobe_go & (ds_done | berr_out);
         ds0_active   <= strobe_go & ~ds_done & ~berr_out; // released on error
         ds1_active   <= strobe_go & ~ds_done & ~berr_out; // released on error
         gnt_done     <= grant_go & (gnt_done | grant_timeout);
         grant_active <= grant_go & ~gnt_done & ~grant_timeout; // withdrawn
         wait_cnt     <= grant_active ? wait_cnt + 4'h1 : 4'h0;
         bbsy_seen    <= grant_active & bbsy_prompt & (bbsy_seen | wait_cnt == 4'h8);
      end
   end
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// self-checking bench for the bus time-out and tick timer block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic        mclk, nrst, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, prev;
   logic        grant_active, bbsy_seen, grant_timeout, ds0_active, ds1_active;
   logic        sys_controller, sysfail_seen, berr_out, dma_on_bus, dma_tenure_end;
   logic        dma_off_hold, access_pending, access_posted, is_bus_master;
   logic        transfer_error_ack, wpost_err_irq, reset_switch, sysreset_out;
   logic        board_fail_pin, strobe_go, grant_go, bbsy_prompt;
   logic [1:0]  tick_irq;
   integer      failures, check_count, n, k, us;
   tmr_bus_timers tmr_bus_timers_inst (.*);
   tmr_vme_far tmr_vme_far_inst (.*);
   // clock
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // verdict and end of run
   task results;
      begin
         $display("checks %0d failures %0d", check_count, failures);
         if (failures == 0 && check_count > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   // a wait that ran out ends the run
   task lost;
      begin
         failures = failures + 1;
         $display("mismatch at %0t: wait ran out", $time);
         results;
      end
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      begin
         check_count = check_count + 1;
         if (seen !== exp) begin
            failures = failures + 1;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
         end
      end
   endtask
   // one apb transfer, held until ready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      integer t;
      begin
         @(posedge mclk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge mclk);
         penable <= 1'b1;
         @(posedge mclk);
         t = 1;
         while (pready !== 1'b1 && t < 20) begin
            @(posedge mclk);
            t = t + 1;
         end
         if (t >= 20)
            lost;
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      begin
         apb(1'b0, a, 32'h0000_0000);
         chk(rd & m, e);
      end
   endtask
   function logic pick(input integer sel);
      case (sel)
         0: pick = tick_irq[0];
         1: pick = tick_irq[1];
         2: pick = berr_out;
         3: pick = grant_timeout;
         4: pick = transfer_error_ack;
         5: pick = wpost_err_irq;
         6: pick = dma_tenure_end;
         7: pick = !dma_off_hold;
         default: pick = board_fail_pin;
      endcase
   endfunction
   // count cycles until a device output is high; quiet waits do not fail when the limit runs out
   task waitfor(input integer sel, input integer lim, input logic quiet);
      begin
         n = 0;
         while (pick(sel) !== 1'b1 && n < lim) begin
            @(posedge mclk);
            n = n + 1;
         end
         if (n >= lim && !quiet)
            lost;
      end
   endtask
   // main sequence
   initial begin
      failures = 0;
      check_count = 0;
      {nrst, psel, penable, pwrite, paddr, pwdata, reset_switch} = '0;
      {dma_on_bus, access_pending, access_posted, is_bus_master} = '0;
      {strobe_go, grant_go, bbsy_prompt} = '0;
      sys_controller = 1'b1;
      sysfail_seen = 1'b1;
      repeat (6) @(posedge mclk);
      nrst <= 1'b1;
      rdc(8'h4c, 32'hffff_ffff, 32'h0000_00df); // time-out word after reset
      rdc(8'h60, 32'h7f00_0000, 32'h7b00_0000); // board flags after reset
      chk(board_fail_pin, 1'b1); // pin follows force bit
      apb(1'b1, 8'h4c, 32'h0000_00ff);
      rdc(8'h4c, 32'hffff_ffff, 32'h0000_00df); // prescaler keeps old value
      apb(1'b1, 8'h4c, 32'h0100_00fe); // two cycles per microsecond
      rdc(8'h4c, 32'hffff_ffff, 32'h0100_00fe); // fields read back
      repeat (256) @(posedge mclk); // past the first reload
      apb(1'b0, 8'h64, 32'h0000_0000);
      prev = rd;
      apb(1'b0, 8'h64, 32'h0000_0000);
      chk({8'h00, rd[31:8]} - {8'h00, prev[31:8]}, 32'h0000_0002); // upper part rate
      rdc(8'h70, 32'hffff_ffff, 32'h0000_0000);
      chk(err, 1'b1);
      apb(1'b1, 8'h60, 32'h0500_0000);
      rdc(8'h60, 32'h1f00_0000, 32'h0100_0000); // flag cleared, clear bit reads 0
      chk(board_fail_pin, 1'b0); // force bit off
      reset_switch <= 1'b1;
      repeat (2) @(posedge mclk);
      chk(sysreset_out, 1'b1); // switch enabled
      apb(1'b1, 8'h60, 32'h0000_0000);
      repeat (2) @(posedge mclk);
      chk(sysreset_out, 1'b0); // switch disabled
      reset_switch <= 1'b0;
      // periodic ticks: clear counters, set compares, then enable
      apb(1'b1, 8'h54, 32'h0000_0000); // counter cleared first
      apb(1'b1, 8'h5c, 32'h0000_0000);
      apb(1'b1, 8'h50, 32'h0000_0003);
      apb(1'b1, 8'h58, 32'h0000_0005);
      apb(1'b1, 8'h60, 32'h0000_0303); // enable with clear-on-compare
      waitfor(0, 40, 1'b0);
      @(posedge mclk);
      waitfor(0, 40, 1'b0);
      chk(n, 5); // period of three ticks
      rdc(8'h60, 32'h0000_00f0, 32'h0000_0020); // overflow count
      rdc(8'h54, 32'hffff_fffc, 32'h0000_0000); // counter cleared on match
      waitfor(1, 40, 1'b0);
      apb(1'b1, 8'h54, 32'h0000_1000);
      rdc(8'h54, 32'hffff_fff0, 32'h0000_1000); // written while counting
      apb(1'b1, 8'h60, 32'h0000_0000);
      // global strobe time-out, every select code, then not system controller
      for (k = 0; k < 5; k = k + 1) begin
         sys_controller <= (k != 4);
         apb(1'b1, 8'h4c, 32'h0100_00fe | ((k % 4) << 16));
         strobe_go <= 1'b1;
         waitfor(2, 600, 1'b1);
         us = (k == 0) ? 8 : (k == 1) ? 64 : 256;
         if (k < 3)
            chk(n >= 2 * us - 2 && n <= 2 * us + 6, 1'b1); // select time
         else
            chk(n, 600); // disabled or not controller
         strobe_go <= 1'b0;
         @(posedge mclk);
      end
      // grant unanswered, then answered promptly
      for (k = 0; k < 2; k = k + 1) begin
         bbsy_prompt <= k[0];
         grant_go <= 1'b1;
         waitfor(3, 700, 1'b1);
         if (k == 0)
            chk(n >= 510 && n <= 518, 1'b1); // grant timeout
         else
            chk(n, 700); // busy seen in time
         grant_go <= 1'b0;
         @(posedge mclk);
      end
      // access time-out: every select, posted and not
      for (k = 0; k < 4; k = k + 1) begin
         apb(1'b1, 8'h4c, 32'h0103_00fe | (k << 14));
         access_posted <= k[0];
         access_pending <= 1'b1;
         waitfor(k[0] ? 5 : 4, (k == 3) ? 300 : 70000, k == 3);
         us = (k == 0) ? 64 : (k == 1) ? 1000 : 32000;
         if (k < 3)
            chk(n >= 2 * us - 2 && n <= 2 * us + 6, 1'b1); // access time
         else
            chk(n, 300); // disabled
         access_pending <= 1'b0;
         @(posedge mclk);
      end
      // dma on and off limits, then watchdog restart and expiry
      apb(1'b1, 8'h4c, 32'h0123_00fe);
      dma_on_bus <= 1'b1;
      waitfor(6, 60, 1'b0);
      chk(n >= 30 && n <= 38, 1'b1); // 16 us on the bus
      dma_on_bus <= 1'b0;
      repeat (2) @(posedge mclk);
      chk(dma_off_hold, 1'b1); // held off
      waitfor(7, 60, 1'b0);
      chk(n >= 28 && n <= 36, 1'b1); // 16 us off
      apb(1'b1, 8'h60, 32'h0009_0000);
      waitfor(8, 700, 1'b1);
      chk(n, 700); // no early expiry
      apb(1'b1, 8'h60, 32'h0029_0000); // restart
      waitfor(8, 1100, 1'b0);
      chk(n >= 1020 && n <= 1034, 1'b1); // 512 us period
      rdc(8'h60, 32'h1010_0000, 32'h1010_0000); // expired, pin up
      results;
   end
endmodule
`default_nettype wire
